// ===== verilog/serial_bus_pkg.sv
`default_nettype none
package serial_bus_pkg;
  // System clock rate and the half period of the generated serial clock.
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HALF_NS = 400;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TMR_W = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control register bits.
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WC = 3;
  localparam int CTL_EN = 2;

  // Status and address register fields.
  localparam int STAT_CODE_LSB = 3;
  localparam int PRESC_W = 2;
  localparam int OWN_LSB = 1;

  // Interrupt status and mask bits.
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_WC = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_W = 3;

  // Bus event codes, upper five bits significant.
  localparam logic [7:0] CODE_NONE = 8'hF8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_AW_ACK = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_DW_ACK = 8'h28;
  localparam logic [7:0] CODE_DW_NACK = 8'h30;
  localparam logic [7:0] CODE_AR_ACK = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_DR_ACK = 8'h50;
  localparam logic [7:0] CODE_DR_NACK = 8'h58;
  localparam logic [7:0] CODE_SW_ADDR = 8'h60;
  localparam logic [7:0] CODE_SR_ACK = 8'h80;
  localparam logic [7:0] CODE_SR_NACK = 8'h88;
  localparam logic [7:0] CODE_S_STOP = 8'hA0;
  localparam logic [7:0] CODE_SR_ADDR = 8'hA8;
  localparam logic [7:0] CODE_ST_ACK = 8'hB8;
  localparam logic [7:0] CODE_ST_NACK = 8'hC0;

  localparam logic [3:0] ACK_SLOT = 4'd8;
  localparam logic [3:0] LAST_DATA_BIT = 4'd7;
  localparam int HTRANS_ACT = 1;

  typedef enum logic [2:0] {ST_IDLE, ST_COND, ST_BYTE, ST_HOLD, ST_STOP} bus_state_t;
endpackage
`default_nettype wire

// ===== verilog/sync_pair.sv
`default_nettype none
module sync_pair #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;
  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d_in;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.sync;
endmodule
`default_nettype wire

// ===== verilog/bit_timer.sv
`default_nettype none
module bit_timer
  import serial_bus_pkg::*;
#(
  parameter int HALF_CYCLES = SCL_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PRESC_W-1:0] presc_in,
  input wire logic run_in,
  output logic tick_out
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic tick;
  } tmr_t;
  tmr_t s_r;
  tmr_t s_nxt;
  logic [TMR_W-1:0] limit;

  // The prescaler multiplies the half period by four per step.
  always_comb begin
    limit = (TMR_W'(HALF_CYCLES) << {presc_in, 1'b0}) - TMR_W'(1);
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run_in) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= limit) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + TMR_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;
endmodule
`default_nettype wire

// ===== verilog/two_wire_transfer_control.sv
`default_nettype none
module two_wire_transfer_control
  import serial_bus_pkg::*;
#(
  parameter int HALF_CYCLES = SCL_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  output logic irq_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  typedef struct packed {
    bus_state_t state;
    logic [1:0] step;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic [4:0] code;
    logic [PRESC_W-1:0] presc;
    logic [6:0] own;
    logic flag;
    logic ack_en;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic master;
    logic slv;
    logic tx;
    logic rd;
    logic addr_ph;
    logic rep;
    logic ack_rx;
    logic busy;
    logic scl_prev;
    logic sda_prev;
    logic scl_oe;
    logic sda_oe;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
  } core_t;

  core_t s_r;
  core_t s_nxt;
  logic rst_meta_r;
  logic rst_n_r;
  logic [1:0] pins_q;
  logic scl_q;
  logic sda_q;
  logic tick;
  logic run;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic set_flag;
  logic ev_wc;
  logic ev_stop;
  logic done;
  logic tx_next;
  logic [31:0] rd_word;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  sync_pair #(.W(2)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_r),
    .d_in({scl_in, sda_in}),
    .q_out(pins_q)
  );

  bit_timer #(.HALF_CYCLES(HALF_CYCLES)) u_tmr (
    .clk_in(clk_in),
    .rst_n_in(rst_n_r),
    .presc_in(s_r.presc),
    .run_in(run),
    .tick_out(tick)
  );

  assign scl_q = pins_q[1];
  assign sda_q = pins_q[0];
  assign scl_rise = scl_q & ~s_r.scl_prev;
  assign scl_fall = ~scl_q & s_r.scl_prev;
  assign start_det = scl_q & s_r.scl_prev & s_r.sda_prev & ~sda_q;
  assign stop_det = scl_q & s_r.scl_prev & ~s_r.sda_prev & sda_q;
  assign run = (s_r.state == ST_COND) || (s_r.state == ST_STOP) || ((s_r.state == ST_BYTE) && s_r.master);

  // Event code for a finished byte, from role, phase, direction and acknowledge.
  function automatic logic [7:0] byte_code(input logic mst, input logic aph, input logic txd,
                                           input logic rdd, input logic ok);
    logic [7:0] c;
    c = CODE_NONE;
    if (mst && aph) begin
      c = rdd ? (ok ? CODE_AR_ACK : CODE_AR_NACK) : (ok ? CODE_AW_ACK : CODE_AW_NACK);
    end else if (mst) begin
      c = txd ? (ok ? CODE_DW_ACK : CODE_DW_NACK) : (ok ? CODE_DR_ACK : CODE_DR_NACK);
    end else if (aph) begin
      c = rdd ? CODE_SR_ADDR : CODE_SW_ADDR;
    end else begin
      c = txd ? (ok ? CODE_ST_ACK : CODE_ST_NACK) : (ok ? CODE_SR_ACK : CODE_SR_NACK);
    end
    return c;
  endfunction

  always_comb begin
    rd_word = '0;
    case (haddr_in[7:0])
      OFS_CTRL: begin
        rd_word[CTL_FLAG] = s_r.flag;
        rd_word[CTL_ACK] = s_r.ack_en;
        rd_word[CTL_STA] = s_r.sta;
        rd_word[CTL_STO] = s_r.sto;
        rd_word[CTL_WC] = s_r.wc;
        rd_word[CTL_EN] = s_r.en;
      end
      OFS_STAT: begin
        rd_word[7:STAT_CODE_LSB] = s_r.code;
        rd_word[PRESC_W-1:0] = s_r.presc;
      end
      OFS_DATA: rd_word[7:0] = s_r.data;
      OFS_ADDR: rd_word[7:OWN_LSB] = s_r.own;
      OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = s_r.irq_st;
      OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = s_r.irq_mask;
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    set_flag = 1'b0;
    ev_wc = 1'b0;
    ev_stop = 1'b0;
    done = 1'b0;
    tx_next = 1'b0;
    s_nxt.scl_prev = scl_q;
    s_nxt.sda_prev = sda_q;
    s_nxt.rdy = 1'b1;
    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        OFS_CTRL: begin
          s_nxt.flag = s_r.flag & ~hwdata_in[CTL_FLAG];
          s_nxt.ack_en = hwdata_in[CTL_ACK];
          s_nxt.sta = hwdata_in[CTL_STA];
          s_nxt.sto = hwdata_in[CTL_STO];
          s_nxt.en = hwdata_in[CTL_EN];
        end
        OFS_STAT: s_nxt.presc = hwdata_in[PRESC_W-1:0];
        OFS_DATA: begin
          if (s_r.flag) begin
            s_nxt.data = hwdata_in[7:0];
            s_nxt.wc = 1'b0;
          end else begin
            s_nxt.wc = 1'b1;
            ev_wc = 1'b1;
          end
        end
        OFS_ADDR: s_nxt.own = hwdata_in[7:OWN_LSB];
        OFS_IRQ_MASK: s_nxt.irq_mask = hwdata_in[IRQ_W-1:0];
        default: s_nxt.wr_pend = 1'b0;
      endcase
    end
    s_nxt.wr_pend = 1'b0;
    if (hsel_in && hready_in && htrans_in[HTRANS_ACT]) begin
      if (hwrite_in) begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.wr_addr = haddr_in[7:0];
      end else begin
        s_nxt.rdata = rd_word;
        if (haddr_in[7:0] == OFS_IRQ_STAT) begin
          s_nxt.irq_st = '0;
        end
      end
    end
    case (s_r.state)
      ST_IDLE: begin
        s_nxt.scl_oe = 1'b0;
        s_nxt.sda_oe = 1'b0;
        if (s_r.sta && !s_r.flag && !s_r.busy && scl_q && sda_q) begin
          s_nxt.state = ST_COND;
          s_nxt.step = 2'd2;
          s_nxt.rep = 1'b0;
        end
      end
      ST_COND: begin
        if (tick) begin
          s_nxt.step = s_r.step + 2'd1;
          case (s_r.step)
            2'd0: s_nxt.sda_oe = 1'b0;
            2'd1: s_nxt.scl_oe = 1'b0;
            2'd2: begin
              if (scl_q) begin
                s_nxt.sda_oe = 1'b1;
              end else begin
                s_nxt.step = s_r.step;
              end
            end
            default: begin
              s_nxt.scl_oe = 1'b1;
              set_flag = 1'b1;
              s_nxt.code = s_r.rep ? CODE_RSTART[7:3] : CODE_START[7:3];
              s_nxt.master = 1'b1;
              s_nxt.slv = 1'b0;
              s_nxt.addr_ph = 1'b1;
              s_nxt.state = ST_HOLD;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          s_nxt.step = s_r.step + 2'd1;
          case (s_r.step)
            2'd0: s_nxt.sda_oe = 1'b1;
            2'd1: s_nxt.scl_oe = 1'b0;
            default: begin
              s_nxt.step = s_r.step;
              if (scl_q) begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.sto = 1'b0;
                s_nxt.master = 1'b0;
                s_nxt.state = ST_IDLE;
                ev_stop = 1'b1;
              end
            end
          endcase
        end
      end
      ST_HOLD: begin
        if (!s_r.flag) begin
          if (s_r.sto) begin
            s_nxt.step = 2'd0;
            if (s_r.master) begin
              s_nxt.state = ST_STOP;
            end else begin
              s_nxt.sto = 1'b0;
              s_nxt.slv = 1'b0;
              s_nxt.scl_oe = 1'b0;
              s_nxt.state = ST_IDLE;
            end
          end else if (s_r.sta && s_r.master) begin
            s_nxt.state = ST_COND;
            s_nxt.step = 2'd0;
            s_nxt.rep = 1'b1;
          end else begin
            tx_next = (s_r.master && s_r.addr_ph) || (s_r.master ? ~s_r.rd : s_r.rd);
            s_nxt.state = ST_BYTE;
            s_nxt.bit_cnt = '0;
            s_nxt.tx = tx_next;
            if (s_r.master && s_r.addr_ph) begin
              s_nxt.rd = s_r.data[0];
            end
            s_nxt.shift = s_r.data;
            s_nxt.sda_oe = tx_next & ~s_r.data[7];
            s_nxt.scl_oe = s_r.master;
          end
        end
      end
      ST_BYTE: begin
        if (tick) begin
          if (s_r.scl_oe) begin
            s_nxt.scl_oe = 1'b0;
          end else if (scl_q) begin
            s_nxt.scl_oe = 1'b1;
          end
        end
        if (scl_rise) begin
          if (s_r.bit_cnt < ACK_SLOT) begin
            s_nxt.shift = {s_r.shift[6:0], sda_q};
          end else begin
            s_nxt.ack_rx = ~sda_q;
          end
        end
        if (scl_fall) begin
          s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
          if (s_r.bit_cnt < LAST_DATA_BIT) begin
            s_nxt.sda_oe = s_r.tx & ~s_r.shift[7];
          end else if (s_r.bit_cnt == LAST_DATA_BIT) begin
            if (s_r.tx) begin
              s_nxt.sda_oe = 1'b0;
            end else if (!s_r.master && s_r.addr_ph) begin
              if ((s_r.shift[7:1] == s_r.own) && s_r.ack_en) begin
                s_nxt.sda_oe = 1'b1;
                s_nxt.slv = 1'b1;
                s_nxt.rd = s_r.shift[0];
              end else begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.state = ST_IDLE;
              end
            end else begin
              s_nxt.sda_oe = s_r.ack_en;
            end
          end else begin
            done = 1'b1;
          end
        end
        if (done) begin
          set_flag = 1'b1;
          s_nxt.code = 5'(byte_code(s_r.master, s_r.addr_ph, s_r.tx, s_r.rd,
                                    s_r.tx ? s_r.ack_rx : s_r.ack_en) >> STAT_CODE_LSB);
          s_nxt.sda_oe = 1'b0;
          s_nxt.scl_oe = 1'b1;
          s_nxt.addr_ph = 1'b0;
          s_nxt.state = ST_HOLD;
          if (!s_r.tx && !s_r.addr_ph) begin
            s_nxt.data = s_r.shift;
          end
          if (!s_r.master && !s_r.addr_ph && (s_r.tx ? !s_r.ack_rx : !s_r.ack_en)) begin
            s_nxt.scl_oe = 1'b0;
            s_nxt.slv = 1'b0;
            s_nxt.state = ST_IDLE;
          end
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    if (start_det && !s_r.master && (s_r.state != ST_HOLD) && (s_r.state != ST_COND)) begin
      s_nxt.state = ST_BYTE;
      s_nxt.bit_cnt = '0;
      s_nxt.addr_ph = 1'b1;
      s_nxt.tx = 1'b0;
      s_nxt.slv = 1'b0;
      s_nxt.scl_oe = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_det && !s_r.master && (s_r.state == ST_BYTE)) begin
      if (s_r.slv) begin
        set_flag = 1'b1;
        s_nxt.code = CODE_S_STOP[7:3];
      end
      s_nxt.slv = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.scl_oe = 1'b0;
      s_nxt.state = ST_IDLE;
    end
    if (start_det) begin
      s_nxt.busy = 1'b1;
    end else if (stop_det) begin
      s_nxt.busy = 1'b0;
    end
    if (!s_r.en) begin
      s_nxt.state = ST_IDLE;
      s_nxt.scl_oe = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.master = 1'b0;
      s_nxt.slv = 1'b0;
      s_nxt.code = s_r.code;
      set_flag = 1'b0;
    end
    s_nxt.flag = s_nxt.flag | set_flag;
    s_nxt.irq_st = s_nxt.irq_st | {ev_stop, ev_wc, set_flag};
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
  end

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
      s_r.code <= CODE_NONE[7:3];
      s_r.scl_prev <= 1'b1;
      s_r.sda_prev <= 1'b1;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout_out = s_r.rdy;
  assign hresp_out = s_r.wr_pend & 1'b0;
  assign hrdata_out = s_r.rdata;
  assign irq_out = s_r.irq;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = s_r.scl_oe;
  assign sda_oe_out = s_r.sda_oe;

  property p_disable_release;
    @(posedge clk_in) disable iff (!rst_n_r) !s_r.en |=> (!s_r.scl_oe && !s_r.sda_oe);
  endproperty
  a_disable_release: assert property (p_disable_release) else $error("lines held while disabled");

  property p_disable_code;
    @(posedge clk_in) disable iff (!rst_n_r) !s_r.en |=> ($stable(s_r.code) && !$rose(s_r.flag));
  endproperty
  a_disable_code: assert property (p_disable_code) else $error("code or flag changed while disabled");

  property p_hold_stall;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_HOLD && s_r.flag && s_r.en && s_r.scl_oe) |=> (s_r.state == ST_HOLD && s_r.scl_oe);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("transfer moved while flag set");

  property p_start_code;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_COND && !s_r.rep && tick && s_r.step == 2'd3 && s_r.en)
      |=> (s_r.flag && s_r.code == CODE_START[7:3] && s_r.state == ST_HOLD);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start not reported");

  property p_byte_flag;
    @(posedge clk_in) disable iff (!rst_n_r) (done && s_r.en) |=> (s_r.flag && s_r.code != CODE_NONE[7:3]);
  endproperty
  a_byte_flag: assert property (p_byte_flag) else $error("flag not set after byte");

  property p_read_bit;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_BYTE && s_r.master && s_r.addr_ph && s_r.bit_cnt == LAST_DATA_BIT && scl_rise && s_r.rd)
      |-> !s_r.sda_oe;
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read bit not high");

  property p_write_bit;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_BYTE && s_r.master && s_r.addr_ph && s_r.bit_cnt == LAST_DATA_BIT && scl_rise && !s_r.rd)
      |-> s_r.sda_oe;
  endproperty
  a_write_bit: assert property (p_write_bit) else $error("write bit not low");

  property p_ack_slot;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_BYTE && s_r.bit_cnt == ACK_SLOT && scl_rise && !s_r.tx && !s_r.addr_ph)
      |-> (s_r.sda_oe == s_r.ack_en);
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("acknowledge slot level wrong");

  property p_tx_release;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_BYTE && s_r.bit_cnt == ACK_SLOT && s_r.tx) |-> !s_r.sda_oe;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("transmitter drove acknowledge slot");

  property p_bit_count;
    @(posedge clk_in) disable iff (!rst_n_r) (s_r.state == ST_BYTE) |-> (s_r.bit_cnt <= ACK_SLOT);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("more than nine bit slots");

  property p_collision;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.wr_pend && s_r.wr_addr == OFS_DATA && !s_r.flag) |=> (s_r.wc && $stable(s_r.data));
  endproperty
  a_collision: assert property (p_collision) else $error("collision write not dropped");

  property p_clear_resume;
    @(posedge clk_in) disable iff (!rst_n_r)
      (s_r.state == ST_HOLD && s_r.flag && s_r.wr_pend && s_r.wr_addr == OFS_CTRL && hwdata_in[CTL_FLAG]
       && hwdata_in[CTL_EN] && !hwdata_in[CTL_STA] && !hwdata_in[CTL_STO] && !done) |=> !s_r.flag ##1 (s_r.state != ST_HOLD);
  endproperty
  a_clear_resume: assert property (p_clear_resume) else $error("flag clear did not resume");

  property p_stop_clears;
    @(posedge clk_in) disable iff (!rst_n_r) (ev_stop && s_r.en) |=> (!s_r.sto && s_r.state == ST_IDLE);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop bit not cleared");
endmodule
`default_nettype wire

// ===== sim/target_model.sv
`default_nettype none
module target_model (
  input wire logic clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en_in,
  input wire logic send_in,
  input wire logic [7:0] tx_byte_in,
  output logic pull_out,
  output logic [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic armed = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [3:0] nc;
  logic [7:0] sh = 8'h00;
  initial pull_out = 1'b0;
  initial byte_out = 8'h00;
  assign nc = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  // The SCL fall that closes a START is not a bit slot, so the first fall only arms the counter.
  always @(posedge clk_in) begin
    ps <= scl_in;
    pd <= sda_in;
    if (scl_in && pd && !sda_in) begin
      cnt <= 4'h0;
      armed <= 1'b0;
      pull_out <= 1'b0;
    end else if (!ps && scl_in && cnt < 4'h8) begin
      sh <= {sh[6:0], sda_in};
    end else if (ps && !scl_in && !armed) begin
      armed <= 1'b1;
    end else if (ps && !scl_in) begin
      cnt <= nc;
      pull_out <= (nc == 4'h8) ? ack_en_in : (send_in & ~tx_byte_in[3'(4'h7 - nc)]);
      if (cnt == 4'h8) byte_out <= sh;
    end else if (!scl_in && cnt == 4'h0 && armed) begin
      pull_out <= send_in & ~tx_byte_in[7];
    end
  end
endmodule
`default_nettype wire

// ===== sim/two_wire_transfer_control_tb.sv
`default_nettype none
module two_wire_transfer_control_tb;
  import serial_bus_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ack_en = 1'b1;
  logic send = 1'b0;
  logic [7:0] txb = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, e, m, g, tmp;
  logic hready, hresp, irq, scl_o, scl_oe, sda_o, sda_oe, pull;
  logic [7:0] rx, b;
  logic [31:0] exp_q[$], msk_q[$], got_q[$];
  logic [7:0] codes [3] = '{CODE_AW_ACK, CODE_DW_ACK, CODE_DW_NACK};
  int err_count = 0;
  int total_checks = 0;
  wire scl_w = !(scl_oe && !scl_o);
  wire sda_w = !(sda_oe && !sda_o) && !pull;
  initial forever #50 clk = ~clk;
  two_wire_transfer_control DUT (.clk_in(clk), .resetn_in(resetn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .irq_out(irq), .scl_in(scl_w),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe));
  target_model partner (.clk_in(clk), .scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en), .send_in(send),
    .tx_byte_in(txb), .pull_out(pull), .byte_out(rx));
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
    logic [31:0] t;
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    bus(1'b0, a, 32'h0, t);
    got_q.push_back(t);
  endtask
  task val_chk(input logic [31:0] ex, input logic [31:0] gt);
    exp_q.push_back(ex);
    msk_q.push_back(32'hFFFFFFFF);
    got_q.push_back(gt);
  endtask
  task wait_flag;
    logic [31:0] t;
    int n;
    t = 32'h0;
    n = 0;
    while (t[CTL_FLAG] !== 1'b1 && n < 300) begin
      bus(1'b0, OFS_CTRL, 32'h0, t);
      n++;
    end
    if (t[CTL_FLAG] !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: flag never set", $time);
    end
  endtask
  task print_verdict;
    wait (got_q.size() == 0);
    #1;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial forever begin
    wait (got_q.size() > 0);
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    g = got_q.pop_front();
    total_checks++;
    if ((g & m) !== (e & m)) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  end
  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
  initial begin
    tmp = $urandom(17645);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(OFS_STAT, {24'h0, CODE_NONE}, 32'hF8);
    val_chk(32'h0, {29'h0, hresp, scl_o, sda_o});
    wr(OFS_DATA, 32'h5A);
    rd_chk(OFS_CTRL, 32'h08, 32'h88);
    rd_chk(OFS_IRQ_STAT, 32'h2, 32'h2);
    wr(OFS_CTRL, 32'hA0);
    repeat (40) @(posedge clk);
    rd_chk(OFS_CTRL, 32'h0, 32'h80);
    val_chk(32'h0, {31'h0, sda_oe | scl_oe});
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CTRL, 32'hA4);
    wait_flag();
    rd_chk(OFS_STAT, {24'h0, CODE_START}, 32'hF8);
    val_chk(32'h1, {31'h0, irq});
    rd_chk(OFS_IRQ_STAT, 32'h1, 32'h1);
    repeat (20) @(posedge clk);
    val_chk(32'h0, {31'h0, irq});
    val_chk(32'h0, {31'h0, scl_w});
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? {tmp[6:0], 1'b0} : 8'($urandom);
      if (i == 3) b = {tmp[14:8], 1'b1};
      ack_en <= (i != 2);
      wr(OFS_DATA, {24'h0, b});
      wr(OFS_CTRL, 32'h84);
      rd_chk(OFS_CTRL, 32'h0, 32'h80);
      wait_flag();
      rd_chk(OFS_STAT, {24'h0, (i == 3) ? CODE_AR_ACK : codes[i]}, 32'hF8);
      val_chk({24'h0, b}, {24'h0, rx});
      if (i == 2) begin
        wr(OFS_CTRL, 32'h94);
        repeat (60) @(posedge clk);
        rd_chk(OFS_CTRL, 32'h04, 32'h94);
        rd_chk(OFS_IRQ_STAT, 32'h4, 32'h4);
        val_chk(32'h1, {31'h0, sda_w & scl_w});
        wr(OFS_CTRL, 32'hA4);
        wait_flag();
        rd_chk(OFS_STAT, {24'h0, CODE_START}, 32'hF8);
      end
    end
    txb <= 8'($urandom);
    send <= 1'b1;
    ack_en <= 1'b0;
    wr(OFS_CTRL, 32'hC4);
    wait_flag();
    rd_chk(OFS_STAT, {24'h0, CODE_DR_ACK}, 32'hF8);
    rd_chk(OFS_DATA, {24'h0, txb}, 32'hFF);
    print_verdict();
  end
endmodule
`default_nettype wire
